/* verilog/acb_core.sv */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module acb_core (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  // axi4-lite slave
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // data memory
  output logic [11:0]                 mem_addr,
  input  wire logic [7:0]             mem_rdata,
  output logic [7:0]                  mem_wdata,
  output logic                        mem_we,
  output logic                        busy
);
  import acb_pkg::*;

  logic [15:0] instr_q, instr_d;
  logic [7:0]  accum_q, accum_d;
  logic [4:0]  status_q, status_d;
  logic [20:0] pc_q, pc_d;
  logic [3:0]  bank_q, bank_d;
  acb_state_t  state_q, state_d;
  logic        is_add, is_addc, is_andf, is_andl, is_brc, is_file;
  logic [7:0]  alu_b, alu_res;
  logic        alu_c, alu_hc, alu_ov, alu_n, alu_z;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        start, wr_fire;
  logic [20:0] next_pc, br_target;

  // opcode decode of the latched instruction
  always_comb begin
    is_add  = instr_q[OP_HI:OP6_LO] == OP_ADD_FILE;
    is_addc = instr_q[OP_HI:OP6_LO] == OP_ADDC_FILE;
    is_andf = instr_q[OP_HI:OP6_LO] == OP_AND_FILE;
    is_andl = instr_q[15:8] == OP_AND_LIT;
    is_brc  = instr_q[15:8] == OP_BR_CARRY;
    is_file = is_add || is_addc || is_andf;
  end

  // bank select: bank bit 0 picks the fixed direct bank, bank bit 1 the bank register
  assign mem_addr = {instr_q[BANK_BIT] ? bank_q : ACCESS_BANK, instr_q[7:0]};
  assign alu_b    = is_andl ? instr_q[7:0] : mem_rdata;

  acb_alu u_alu (
    .a      (accum_q),
    .b      (alu_b),
    .cin    (is_addc & status_q[ST_C]),
    .do_and (is_andf | is_andl),
    .res    (alu_res),
    .c      (alu_c),
    .hc     (alu_hc),
    .ov     (alu_ov),
    .n      (alu_n),
    .z      (alu_z)
  );

  // file writeback is combinational during the single exec cycle
  assign mem_wdata = alu_res;
  assign mem_we    = (state_q == ACB_EXEC) && is_file && instr_q[DEST_BIT];
  assign busy      = (state_q != ACB_IDLE);

  // pc points at the branch, target counts from pc plus 2; offset sign-extended and doubled
  assign next_pc   = pc_q + 21'h000002;
  assign br_target = next_pc + {{12{instr_q[7]}}, instr_q[7:0], 1'b0};

  assign wr_fire = aw_q && w_q && !bv_q;
  assign start   = wr_fire && (awa_q == REG_INSTR) && (state_q == ACB_IDLE);

  // execution sequencer and architectural state
  always_comb begin
    state_d  = state_q;
    accum_d  = accum_q;
    status_d = status_q;
    pc_d     = pc_q;
    instr_d  = instr_q;
    bank_d   = bank_q;
    case (state_q)
      ACB_IDLE: begin
        if (start) begin
          instr_d = wd_q[15:0];
          state_d = ACB_EXEC;
        end
      end
      ACB_EXEC: begin
        state_d = ACB_IDLE;
        pc_d    = next_pc;
        if (is_add || is_addc) begin
          status_d[ST_C]  = alu_c;
          status_d[ST_HC] = alu_hc;
          status_d[ST_OV] = alu_ov;
          status_d[ST_N]  = alu_n;
          status_d[ST_Z]  = alu_z;
        end
        if (is_andf || is_andl) begin
          status_d[ST_N] = alu_n;
          status_d[ST_Z] = alu_z;
        end
        if ((is_file && !instr_q[DEST_BIT]) || is_andl) begin
          accum_d = alu_res;
        end
        if (is_brc && status_q[ST_C]) begin
          pc_d    = br_target;
          state_d = ACB_FLUSH;
        end
      end
      ACB_FLUSH: begin
        state_d = ACB_IDLE;
      end
      default: state_d = ACB_IDLE;
    endcase
    // software writes are refused while an instruction is running
    if (wr_fire && state_q == ACB_IDLE) begin
      case (awa_q)
        REG_ACCUM:  accum_d  = wd_q[7:0];
        REG_STATUS: status_d = wd_q[4:0];
        REG_PC:     pc_d     = wd_q[20:0];
        REG_BANK:   bank_d   = wd_q[3:0];
        default: ;
      endcase
    end
  end

  // axi4-lite channel capture and responses
  always_comb begin
    aw_d  = aw_q;
    awa_d = awa_q;
    w_d   = w_q;
    wd_d  = wd_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = RESP_OKAY;
      if (awa_q > REG_BANK || awa_q[1:0] != 2'b00) begin
        br_d = RESP_SLVERR;
      end
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL:   rd_d = {31'h00000000, busy};
        REG_INSTR:  rd_d = {16'h0000, instr_q};
        REG_ACCUM:  rd_d = {24'h000000, accum_q};
        REG_STATUS: rd_d = {27'h0000000, status_q};
        REG_PC:     rd_d = {11'h000, pc_q};
        REG_BANK:   rd_d = {28'h0000000, bank_q};
        default: begin
          rd_d = 32'h00000000;
          rr_d = RESP_SLVERR;
        end
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // registers only; synchronous active-low reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q  <= ACB_IDLE;
      instr_q  <= 16'h0000;
      accum_q  <= ACCUM_RST;
      status_q <= STATUS_RST;
      pc_q     <= PC_RST;
      bank_q   <= BANK_RST;
      aw_q     <= 1'b0;
      awa_q    <= 8'h00;
      w_q      <= 1'b0;
      wd_q     <= 32'h00000000;
      bv_q     <= 1'b0;
      br_q     <= RESP_OKAY;
      rv_q     <= 1'b0;
      rd_q     <= 32'h00000000;
      rr_q     <= RESP_OKAY;
    end else begin
      state_q  <= state_d;
      instr_q  <= instr_d;
      accum_q  <= accum_d;
      status_q <= status_d;
      pc_q     <= pc_d;
      bank_q   <= bank_d;
      aw_q     <= aw_d;
      awa_q    <= awa_d;
      w_q      <= w_d;
      wd_q     <= wd_d;
      bv_q     <= bv_d;
      br_q     <= br_d;
      rv_q     <= rv_d;
      rd_q     <= rd_d;
      rr_q     <= rr_d;
    end
  end

  // branch flushes one cycle only when carry set
  sequence taken_s;
    state_q == ACB_EXEC && is_brc && status_q[ST_C];
  endsequence
  branch_flush_a: assert property (@(posedge clock) disable iff (!nrst)
    taken_s |=> state_q == ACB_FLUSH ##1 state_q == ACB_IDLE)
    else $error("taken branch did not idle one cycle");
  branch_flags_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_brc |=> status_q == $past(status_q))
    else $error("branch changed status");
  branch_target_a: assert property (@(posedge clock) disable iff (!nrst)
    taken_s |=> pc_q == $past(br_target))
    else $error("branch target wrong");
  no_branch_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_brc && !status_q[ST_C] |=> state_q == ACB_IDLE)
    else $error("untaken branch took two cycles");
  file_write_a: assert property (@(posedge clock) disable iff (!nrst)
    mem_we |-> instr_q[DEST_BIT] && is_file)
    else $error("file write without dest bit");
  // file destination must strobe memory and leave the accumulator alone
  file_dest_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_file && instr_q[DEST_BIT]
    |-> mem_we ##1 accum_q == $past(accum_q))
    else $error("file destination did not write memory");
  bank_sel_a: assert property (@(posedge clock) disable iff (!nrst)
    !instr_q[BANK_BIT] |-> mem_addr[11:8] == ACCESS_BANK)
    else $error("access bank not used");
  add_result_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_add && !instr_q[DEST_BIT]
    |=> accum_q == 8'($past(accum_q) + $past(mem_rdata)))
    else $error("add result wrong");
  addc_result_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_addc && !instr_q[DEST_BIT]
    |=> accum_q == 8'($past(accum_q) + $past(mem_rdata) + {7'h00, $past(status_q[ST_C])}))
    else $error("add with carry wrong");
  and_flags_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && (is_andl || is_andf)
    |=> status_q[2:0] == {$past(alu_z), $past(status_q[1:0])} && status_q[ST_OV] == $past(status_q[ST_OV]))
    else $error("and altered c dc or ov");
  add_flags_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && (is_add || is_addc) |=> status_q[ST_C] == $past(alu_c)
    && status_q[ST_HC] == $past(alu_hc) && status_q[ST_OV] == $past(alu_ov))
    else $error("add flags wrong");
  and_lit_result_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_andl
    |=> accum_q == ($past(accum_q) & $past(instr_q[7:0])))
    else $error("and literal result wrong");
  and_file_result_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_andf && !instr_q[DEST_BIT]
    |=> accum_q == ($past(accum_q) & $past(mem_rdata)))
    else $error("and file result wrong");
  // carries judged from plain sums so a broken alu cannot hide behind itself
  add_carry_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_add
    |=> status_q[ST_C] == (({1'b0, $past(accum_q)} + {1'b0, $past(mem_rdata)}) > 9'h0FF))
    else $error("carry out of bit 7 wrong");
  half_carry_a: assert property (@(posedge clock) disable iff (!nrst)
    state_q == ACB_EXEC && is_add
    |=> status_q[ST_HC]
        == (({1'b0, $past(accum_q[3:0])} + {1'b0, $past(mem_rdata[3:0])}) > 5'h0F))
    else $error("carry out of bit 3 wrong");
endmodule : acb_core

/* verilog/acb_pkg.sv */
package acb_pkg;
  // instruction word fields
  localparam int          OP_HI          = 15;
  localparam int          OP6_LO         = 10;
  localparam int          DEST_BIT       = 9;
  localparam int          BANK_BIT       = 8;
  localparam logic [5:0]  OP_ADD_FILE    = 6'h09;  // 0010 01
  localparam logic [5:0]  OP_ADDC_FILE   = 6'h08;  // 0010 00
  localparam logic [5:0]  OP_AND_FILE    = 6'h05;  // 0001 01
  localparam logic [7:0]  OP_AND_LIT     = 8'h0B;  // 0000 1011
  localparam logic [7:0]  OP_BR_CARRY    = 8'hE2;  // 1110 0010
  // status bit positions
  localparam int          ST_C           = 0;
  localparam int          ST_HC          = 1;
  localparam int          ST_Z           = 2;
  localparam int          ST_OV          = 3;
  localparam int          ST_N           = 4;
  // reset values
  localparam logic [7:0]  ACCUM_RST      = 8'h00;
  localparam logic [4:0]  STATUS_RST     = 5'h00;
  localparam logic [20:0] PC_RST         = 21'h000000;
  localparam logic [3:0]  BANK_RST       = 4'h0;
  // fixed direct bank for bank bit 0
  localparam logic [3:0]  ACCESS_BANK    = 4'h0;
  // register offsets on the control bus
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_INSTR      = 8'h04;
  localparam logic [7:0]  REG_ACCUM      = 8'h08;
  localparam logic [7:0]  REG_STATUS     = 8'h0C;
  localparam logic [7:0]  REG_PC         = 8'h10;
  localparam logic [7:0]  REG_BANK       = 8'h14;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [2:0] {
    ACB_IDLE  = 3'b001,
    ACB_EXEC  = 3'b010,
    ACB_FLUSH = 3'b100
  } acb_state_t;
endpackage : acb_pkg

/* verilog/acb_alu.sv */
`timescale 1ns/1ps
// combinational adder / and unit with status generation
module acb_alu (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       do_and,
  output logic      [7:0] res,
  output logic            c,
  output logic            hc,
  output logic            ov,
  output logic            n,
  output logic            z
);
  logic [8:0] sum;
  logic [4:0] low;

  // bit 3 and bit 7 carries, like-sign overflow
  always_comb begin
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    res = do_and ? (a & b) : sum[7:0];
    c   = sum[8];
    hc  = low[4];
    ov  = (a[7] == b[7]) && (sum[7] != a[7]);
    n   = res[7];
    z   = (res == 8'h00);
  end
endmodule : acb_alu

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import acb_pkg::*;
  logic        clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, mem_we, busy;
  logic [7:0]  awaddr, araddr, mem_rdata, mem_wdata;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [11:0] mem_addr;
  logic [7:0]  mem [4096];
  logic [31:0] rnd = 32'h2304;
  int          errors, check_count, busy_total;

  acb_core DUT (
    .clock(clock), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .busy(busy)
  );

  // clock at 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // data memory: combinational read, write on the strobe edge
  assign mem_rdata = mem[mem_addr];
  always @(posedge clock) begin
    if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
    if (busy === 1'b1) busy_total <= busy_total + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // handshakes are judged in the low phase, where nothing moves
  // an idle edge before each request keeps a just-lowered ready from rising in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, fin;
    fin = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!fin) begin
      @(negedge clock);
      ah = awvalid && awready;
      wh = wvalid && wready;
      fin = bvalid;
      r = bresp;
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (fin) bready <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, fin;
    fin = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!fin) begin
      @(negedge clock);
      ah = arvalid && arready;
      fin = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ah) arvalid <= 1'b0;
      if (fin) rready <= 1'b0;
    end
  endtask : rd

  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // watchdog sized well above the expected 8000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    report_and_stop;
  end

  // random instructions against an integer model of the core
  initial begin
    logic [7:0] acc, fv, res, lit;
    logic [4:0] st;
    logic [20:0] pc;
    logic [3:0] bank;
    logic [8:0] sum;
    logic [11:0] ma;
    logic [15:0] ins;
    logic [31:0] d;
    logic [1:0] r;
    logic tk, cin, dst, ab;
    int kind, b0, nb;
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    pc = PC_RST;
    for (int i = 0; i < 4096; i++) begin
      rnd = lfsr(rnd);
      mem[i] = rnd[7:0];
    end
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(REG_PC, d, r);
    chk("pc reset", {11'h0, PC_RST}, d);
    rd(8'h20, d, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h22, 32'h0, r);
    chk("unaligned write", {30'h0, RESP_SLVERR}, {30'h0, r});
    // start from a random even pc so the pc write path is exercised
    rnd = lfsr(rnd);
    pc = {rnd[20:1], 1'b0};
    wr(REG_PC, {11'h0, pc}, r);
    chk("pc write", {30'h0, RESP_OKAY}, {30'h0, r});
    for (int i = 0; i < 250; i++) begin
      kind = i % 5;
      rnd = lfsr(rnd);
      {ab, dst, bank, st, acc} = rnd[18:0];
      rnd = lfsr(rnd);
      {fv, lit} = rnd[15:0];
      wr(REG_ACCUM, {24'h0, acc}, r);
      wr(REG_STATUS, {27'h0, st}, r);
      wr(REG_BANK, {28'h0, bank}, r);
      ma = {ab ? bank : ACCESS_BANK, lit};
      mem[ma] = fv;
      cin = (kind == 1) ? st[ST_C] : 1'b0;
      sum = {1'b0, acc} + {1'b0, fv} + {8'h00, cin};
      res = (kind < 2) ? sum[7:0] : ((kind == 2) ? (acc & fv) : (acc & lit));
      tk = (kind == 4) && st[ST_C];
      case (kind)
        0: ins = {OP_ADD_FILE, dst, ab, lit};
        1: ins = {OP_ADDC_FILE, dst, ab, lit};
        2: ins = {OP_AND_FILE, dst, ab, lit};
        3: ins = {OP_AND_LIT, lit};
        default: ins = {OP_BR_CARRY, lit};
      endcase
      b0 = busy_total;
      wr(REG_INSTR, {16'h0, ins}, r);
      chk("instr resp", {30'h0, RESP_OKAY}, {30'h0, r});
      nb = 0;
      @(negedge clock);
      while (busy !== 1'b0 && nb < 8) begin
        @(negedge clock);
        nb++;
      end
      @(posedge clock);
      chk("busy cycles", tk ? 2 : 1, busy_total - b0);
      if (kind < 2) begin
        st = {res[7], (acc[7] == fv[7]) && (res[7] != acc[7]), res == 8'h00,
              ({1'b0, acc[3:0]} + {1'b0, fv[3:0]} + {4'h0, cin}) > 5'd15, sum[8]};
      end else if (kind < 4) begin
        st[ST_N] = res[7];
        st[ST_Z] = (res == 8'h00);
      end
      if (kind == 3 || (kind < 3 && !dst)) acc = res;
      else if (kind < 3) fv = res;
      pc = pc + 21'd2 + (tk ? {{12{lit[7]}}, lit, 1'b0} : 21'h0);
      rd(REG_ACCUM, d, r);
      chk("accum", {24'h0, acc}, d);
      rd(REG_STATUS, d, r);
      chk("status", {27'h0, st}, d);
      rd(REG_PC, d, r);
      chk("pc", {11'h0, pc}, d);
      rd(REG_INSTR, d, r);
      chk("instr readback", {16'h0, ins}, d);
      rd(REG_CTRL, d, r);
      chk("busy idle", 32'h0, d);
      chk("memory", {24'h0, fv}, {24'h0, mem[ma]});
    end
    report_and_stop;
  end
endmodule : tb_top
